// ===== shared/prm_cfg.svh
//------------------------------------------------------------------------------
// Purpose: Constants for the barometer register map and threshold interrupt.
// Assumes: Included by its bare name wherever a constant is needed.
// Notes:   Offsets are 7-bit register addresses, values are 8-bit.
//------------------------------------------------------------------------------
// Notes on behaviour
// - Registers selected by a seven-bit address.
// - Registers are 8 bits, power-up defaults.
// - Calibration restored at power-up; host leaves alone.
// - Interrupt config field order, all default zero.
// - High above +threshold, low below -threshold.
// - Latch bit holds requests in flag register.
// - Zero capture stores reference; output, compare subtract.
// - Zero capture enable self-clears after conversion.
// - Zero reset restores normal mode, clears reference.
// - Compare-only capture; output subtracts offset registers.
// - Compare-only enable self-clears; its reset restores.
// - Threshold is 16-bit unsigned, sixteenths of hPa.
// - Low register bits 7-0, high 15-8.
// - Auto-increment, default on, advances address per byte.
// - Frame bit0 direction, bits1-7 address, then data.
`ifndef PRM_CFG_SVH
`define PRM_CFG_SVH

// -----------------------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------------------
`define PRM_A_IRQ_CFG   7'h0b
`define PRM_A_THR_LO    7'h0c
`define PRM_A_THR_HI    7'h0d
`define PRM_A_IDENT     7'h0f
`define PRM_A_CTRL1     7'h10
`define PRM_A_CTRL2     7'h11
`define PRM_A_CTRL3     7'h12
`define PRM_A_QCFG      7'h14
`define PRM_A_REF0      7'h15
`define PRM_A_REF1      7'h16
`define PRM_A_REF2      7'h17
`define PRM_A_OFS_LO    7'h18
`define PRM_A_OFS_HI    7'h19
`define PRM_A_RES_CFG   7'h1a
`define PRM_A_FLAGS     7'h25
`define PRM_A_QSTATE    7'h26
`define PRM_A_STATUS    7'h27
`define PRM_A_PRES0     7'h28
`define PRM_A_PRES1     7'h29
`define PRM_A_PRES2     7'h2a
`define PRM_A_TEMP_LO   7'h2b
`define PRM_A_TEMP_HI   7'h2c
`define PRM_A_FILT_CLR  7'h33

// -----------------------------------------------------------------------------
// Reset values and fields
// -----------------------------------------------------------------------------
`define PRM_RST_ZERO    8'h00
`define PRM_RST_CTRL2   8'h10
`define PRM_B_IREF_EN   7
`define PRM_B_IREF_CLR  6
`define PRM_B_ZREF_EN   5
`define PRM_B_ZREF_CLR  4
`define PRM_B_THR_EN    3
`define PRM_B_LATCH     2
`define PRM_B_LOW_EN    1
`define PRM_B_HIGH_EN   0
`define PRM_B_AUTO_INC  4
`define PRM_B_FLAG_ANY  2
`define PRM_B_FLAG_LOW  1
`define PRM_B_FLAG_HIGH 0
`define PRM_B_ST_PRES   0
`define PRM_B_ST_TEMP   1
`define PRM_BIT_LAST    3'h7
`define PRM_THR_SHIFT   8

`endif

// ===== shared/prm_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Types shared by the barometer register map.
// Assumes: Constants come from prm_cfg.svh.
// Notes:   Types only.
//------------------------------------------------------------------------------
package prm_pkg;

    typedef enum logic [1:0] {
        PRM_IDLE,
        PRM_CMD,
        PRM_DATA
    } prm_phase_e;

    typedef logic [7:0] prm_byte_t;

endpackage

// ===== design/prm_reg_map.sv
//------------------------------------------------------------------------------
// Purpose: Register map, serial slave and pressure threshold interrupt.
// Assumes: Serial pins are far slower than core_clk_i; samples arrive as pulses.
// Notes:   Each serial pin passes two flip-flops before use.
//------------------------------------------------------------------------------
`timescale 1ns/1ns
`include "prm_cfg.svh"

module prm_reg_map #(
    // Arbitrary identity value.
    parameter logic [7:0] ID_VALUE = 8'h5a
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_clk_i,
    input  wire logic        spi_sdi_i,
    output logic             spi_sdo_o,
    output logic             spi_sdo_oe_o,
    input  wire logic        meas_valid_i,
    input  wire logic [23:0] meas_press_i,
    input  wire logic [15:0] meas_temp_i,
    output logic             irq_o
);

    // -------------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------------
    logic [1:0] cs_sync_r;
    logic [1:0] clk_sync_r;
    logic [1:0] sdi_sync_r;
    logic       clk_prev_r;
    logic       cs_n_s;
    logic       clk_s;
    logic       sdi_s;
    logic       clk_rise;
    logic       clk_fall;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cs_sync_r  <= 2'h3;
            clk_sync_r <= 2'h3;
            sdi_sync_r <= 2'h0;
            clk_prev_r <= 1'b1;
        end
        else
        begin
            cs_sync_r  <= {cs_sync_r[0], spi_cs_n_i};
            clk_sync_r <= {clk_sync_r[0], spi_clk_i};
            sdi_sync_r <= {sdi_sync_r[0], spi_sdi_i};
            clk_prev_r <= clk_sync_r[1];
        end
    end

    assign cs_n_s   = cs_sync_r[1];
    assign clk_s    = clk_sync_r[1];
    assign sdi_s    = sdi_sync_r[1];
    assign clk_rise = clk_s & ~clk_prev_r;
    assign clk_fall = ~clk_s & clk_prev_r;

    // -------------------------------------------------------------------------
    // Register storage
    // -------------------------------------------------------------------------
    prm_pkg::prm_byte_t irq_config_r;
    prm_pkg::prm_byte_t threshold_low_r;
    prm_pkg::prm_byte_t threshold_high_r;
    prm_pkg::prm_byte_t control_one_r;
    prm_pkg::prm_byte_t control_two_r;
    prm_pkg::prm_byte_t control_three_r;
    prm_pkg::prm_byte_t queue_config_r;
    prm_pkg::prm_byte_t resolution_config_r;
    logic [23:0]        reference_r;
    logic [15:0]        pressure_offset_val_r;
    logic [23:0]        pressure_result_r;
    logic [15:0]        temperature_r;
    prm_pkg::prm_byte_t irq_flags_r;
    prm_pkg::prm_byte_t status_flags_r;
    logic               zero_mode_r;
    logic               irq_ref_mode_r;
    logic               irq_r;

    // -------------------------------------------------------------------------
    // Serial slave state
    // -------------------------------------------------------------------------
    prm_pkg::prm_phase_e phase_r;
    logic [2:0]          bit_cnt_r;
    prm_pkg::prm_byte_t  rx_shift_r;
    prm_pkg::prm_byte_t  tx_shift_r;
    logic                read_r;
    logic [6:0]          addr_r;
    logic                wr_en_r;
    logic [6:0]          wr_addr_r;
    prm_pkg::prm_byte_t  wr_data_r;
    logic                rd_flags_r;
    logic                rd_pres_r;
    logic                rd_temp_r;
    logic                sdo_r;
    logic                sdo_oe_r;

    prm_pkg::prm_byte_t  rx_nxt;
    logic [6:0]          addr_adv;
    logic [6:0]          rd_addr;
    logic                rd_go;
    prm_pkg::prm_byte_t  rd_data;

    assign rx_nxt   = {rx_shift_r[6:0], sdi_s};
    assign addr_adv = control_two_r[`PRM_B_AUTO_INC] ? addr_r + 7'h01 : addr_r;
    // The address byte starts with the direction bit, address after it.
    assign rd_addr  = (phase_r == prm_pkg::PRM_CMD) ? rx_nxt[6:0] : addr_adv;
    assign rd_go    = clk_rise && (bit_cnt_r == `PRM_BIT_LAST) &&
                      (((phase_r == prm_pkg::PRM_CMD) && rx_nxt[7]) ||
                       ((phase_r == prm_pkg::PRM_DATA) && read_r));

    // -------------------------------------------------------------------------
    // Read multiplexer
    // -------------------------------------------------------------------------
    always_comb
    begin
        case (rd_addr)
            `PRM_A_IRQ_CFG:  rd_data = irq_config_r;
            `PRM_A_THR_LO:   rd_data = threshold_low_r;
            `PRM_A_THR_HI:   rd_data = threshold_high_r;
            `PRM_A_IDENT:    rd_data = ID_VALUE;
            `PRM_A_CTRL1:    rd_data = control_one_r;
            `PRM_A_CTRL2:    rd_data = control_two_r;
            `PRM_A_CTRL3:    rd_data = control_three_r;
            `PRM_A_QCFG:     rd_data = queue_config_r;
            `PRM_A_REF0:     rd_data = reference_r[7:0];
            `PRM_A_REF1:     rd_data = reference_r[15:8];
            `PRM_A_REF2:     rd_data = reference_r[23:16];
            `PRM_A_OFS_LO:   rd_data = pressure_offset_val_r[7:0];
            `PRM_A_OFS_HI:   rd_data = pressure_offset_val_r[15:8];
            `PRM_A_RES_CFG:  rd_data = resolution_config_r;
            `PRM_A_FLAGS:    rd_data = irq_flags_r;
            `PRM_A_STATUS:   rd_data = status_flags_r;
            `PRM_A_PRES0:    rd_data = pressure_result_r[7:0];
            `PRM_A_PRES1:    rd_data = pressure_result_r[15:8];
            `PRM_A_PRES2:    rd_data = pressure_result_r[23:16];
            `PRM_A_TEMP_LO:  rd_data = temperature_r[7:0];
            `PRM_A_TEMP_HI:  rd_data = temperature_r[15:8];
            default:         rd_data = `PRM_RST_ZERO;
        endcase
    end

    // -------------------------------------------------------------------------
    // Serial frame sequencing
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            phase_r    <= prm_pkg::PRM_IDLE;
            bit_cnt_r  <= 3'h0;
            rx_shift_r <= `PRM_RST_ZERO;
            read_r     <= 1'b0;
            addr_r     <= 7'h00;
            wr_en_r    <= 1'b0;
            wr_addr_r  <= 7'h00;
            wr_data_r  <= `PRM_RST_ZERO;
        end
        else
        begin
            wr_en_r <= 1'b0;
            if (cs_n_s)
            begin
                phase_r   <= prm_pkg::PRM_IDLE;
                bit_cnt_r <= 3'h0;
            end
            else if (phase_r == prm_pkg::PRM_IDLE)
            begin
                phase_r <= prm_pkg::PRM_CMD;
            end
            else if (clk_rise)
            begin
                rx_shift_r <= rx_nxt;
                bit_cnt_r  <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == `PRM_BIT_LAST)
                begin
                    case (phase_r)
                        prm_pkg::PRM_CMD:
                        begin
                            read_r  <= rx_nxt[7];
                            addr_r  <= rx_nxt[6:0];
                            phase_r <= prm_pkg::PRM_DATA;
                        end
                        prm_pkg::PRM_DATA:
                        begin
                            wr_en_r   <= ~read_r;
                            wr_addr_r <= addr_r;
                            wr_data_r <= rx_nxt;
                            addr_r    <= addr_adv;
                        end
                        default:
                        begin
                            phase_r <= prm_pkg::PRM_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Read data out and read side effects
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_shift_r <= `PRM_RST_ZERO;
            sdo_r      <= 1'b0;
            sdo_oe_r   <= 1'b0;
            rd_flags_r <= 1'b0;
            rd_pres_r  <= 1'b0;
            rd_temp_r  <= 1'b0;
        end
        else
        begin
            rd_flags_r <= rd_go && (rd_addr == `PRM_A_FLAGS);
            rd_pres_r  <= rd_go && (rd_addr == `PRM_A_PRES2);
            rd_temp_r  <= rd_go && (rd_addr == `PRM_A_TEMP_HI);
            sdo_oe_r   <= ~cs_n_s && (phase_r == prm_pkg::PRM_DATA) && read_r;
            if (rd_go)
            begin
                tx_shift_r <= rd_data;
            end
            else if (clk_fall && (phase_r == prm_pkg::PRM_DATA) && read_r)
            begin
                sdo_r      <= tx_shift_r[7];
                tx_shift_r <= {tx_shift_r[6:0], 1'b0};
            end
        end
    end

    // -------------------------------------------------------------------------
    // Conversion arithmetic
    // -------------------------------------------------------------------------
    logic        cap_zero;
    logic        cap_iref;
    logic [23:0] ref_use;
    logic [24:0] compare_delta;
    logic [24:0] thr_ext;
    logic        evt_high;
    logic        evt_low;
    logic [23:0] result_nxt;
    logic        evt_any;

    assign cap_zero = irq_config_r[`PRM_B_ZREF_EN];
    assign cap_iref = irq_config_r[`PRM_B_IREF_EN];
    // A capture takes this very sample as the reference.
    assign ref_use  = (cap_zero | cap_iref) ? meas_press_i : reference_r;
    assign compare_delta = {1'b0, meas_press_i} - {1'b0, ref_use};
    // One hPa is 4096 counts and the threshold is in sixteenths of it.
    assign thr_ext = {1'b0, threshold_high_r, threshold_low_r, 8'h00};
    assign evt_high = irq_config_r[`PRM_B_THR_EN] && irq_config_r[`PRM_B_HIGH_EN] &&
                      ($signed(compare_delta) > $signed(thr_ext));
    assign evt_low  = irq_config_r[`PRM_B_THR_EN] && irq_config_r[`PRM_B_LOW_EN] &&
                      ($signed(compare_delta) < -$signed(thr_ext));
    assign evt_any  = evt_high | evt_low;

    always_comb
    begin
        if (zero_mode_r | cap_zero)
        begin
            result_nxt = meas_press_i - ref_use;
        end
        else if (irq_ref_mode_r | cap_iref)
        begin
            result_nxt = meas_press_i -
                         {{8{pressure_offset_val_r[15]}}, pressure_offset_val_r};
        end
        else
        begin
            result_nxt = meas_press_i;
        end
    end

    // -------------------------------------------------------------------------
    // Configuration, reference and mode registers
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_config_r          <= `PRM_RST_ZERO;
            threshold_low_r       <= `PRM_RST_ZERO;
            threshold_high_r      <= `PRM_RST_ZERO;
            control_one_r         <= `PRM_RST_ZERO;
            control_two_r         <= `PRM_RST_CTRL2;
            control_three_r       <= `PRM_RST_ZERO;
            queue_config_r        <= `PRM_RST_ZERO;
            resolution_config_r   <= `PRM_RST_ZERO;
            reference_r           <= 24'h000000;
            pressure_offset_val_r <= 16'h0000;
            zero_mode_r           <= 1'b0;
            irq_ref_mode_r        <= 1'b0;
        end
        else
        begin
            // Reserved and unlisted addresses fall to the default and are dropped.
            if (wr_en_r)
            begin
                case (wr_addr_r)
                    `PRM_A_IRQ_CFG:
                    begin
                        // The two clear bits act once and never store.
                        irq_config_r <= wr_data_r &
                            ~((8'h01 << `PRM_B_IREF_CLR) | (8'h01 << `PRM_B_ZREF_CLR));
                        if (wr_data_r[`PRM_B_ZREF_CLR])
                        begin
                            zero_mode_r <= 1'b0;
                            reference_r <= 24'h000000;
                        end
                        if (wr_data_r[`PRM_B_IREF_CLR])
                        begin
                            irq_ref_mode_r <= 1'b0;
                        end
                    end
                    `PRM_A_THR_LO:  threshold_low_r              <= wr_data_r;
                    `PRM_A_THR_HI:  threshold_high_r             <= wr_data_r;
                    `PRM_A_CTRL1:   control_one_r                <= wr_data_r;
                    `PRM_A_CTRL2:   control_two_r                <= wr_data_r;
                    `PRM_A_CTRL3:   control_three_r              <= wr_data_r;
                    `PRM_A_QCFG:    queue_config_r               <= wr_data_r;
                    `PRM_A_REF0:    reference_r[7:0]             <= wr_data_r;
                    `PRM_A_REF1:    reference_r[15:8]            <= wr_data_r;
                    `PRM_A_REF2:    reference_r[23:16]           <= wr_data_r;
                    `PRM_A_OFS_LO:  pressure_offset_val_r[7:0]   <= wr_data_r;
                    `PRM_A_OFS_HI:  pressure_offset_val_r[15:8]  <= wr_data_r;
                    `PRM_A_RES_CFG: resolution_config_r          <= wr_data_r;
                    default:        control_three_r              <= control_three_r;
                endcase
            end
            // A conversion outranks a host write in the same cycle.
            if (meas_valid_i && (cap_zero | cap_iref))
            begin
                reference_r <= meas_press_i;
                if (cap_zero)
                begin
                    zero_mode_r                   <= 1'b1;
                    irq_config_r[`PRM_B_ZREF_EN]  <= 1'b0;
                end
                if (cap_iref)
                begin
                    irq_ref_mode_r                <= 1'b1;
                    irq_config_r[`PRM_B_IREF_EN]  <= 1'b0;
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Output data and status
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pressure_result_r <= 24'h000000;
            temperature_r     <= 16'h0000;
            status_flags_r    <= `PRM_RST_ZERO;
        end
        else
        begin
            if (meas_valid_i)
            begin
                pressure_result_r <= result_nxt;
                temperature_r     <= meas_temp_i;
            end
            // A new sample wins over the read that would clear its flag.
            status_flags_r[`PRM_B_ST_PRES] <= meas_valid_i |
                (status_flags_r[`PRM_B_ST_PRES] & ~rd_pres_r);
            status_flags_r[`PRM_B_ST_TEMP] <= meas_valid_i |
                (status_flags_r[`PRM_B_ST_TEMP] & ~rd_temp_r);
        end
    end

    // -------------------------------------------------------------------------
    // Interrupt flags
    // -------------------------------------------------------------------------
    prm_pkg::prm_byte_t flags_nxt;

    always_comb
    begin
        flags_nxt = irq_flags_r;
        if (irq_config_r[`PRM_B_LATCH])
        begin
            if (rd_flags_r)
            begin
                flags_nxt = `PRM_RST_ZERO;
            end
            if (meas_valid_i)
            begin
                flags_nxt[`PRM_B_FLAG_HIGH] = flags_nxt[`PRM_B_FLAG_HIGH] | evt_high;
                flags_nxt[`PRM_B_FLAG_LOW]  = flags_nxt[`PRM_B_FLAG_LOW] | evt_low;
                flags_nxt[`PRM_B_FLAG_ANY]  = flags_nxt[`PRM_B_FLAG_ANY] | evt_any;
            end
        end
        else if (meas_valid_i)
        begin
            flags_nxt = `PRM_RST_ZERO;
            flags_nxt[`PRM_B_FLAG_HIGH] = evt_high;
            flags_nxt[`PRM_B_FLAG_LOW]  = evt_low;
            flags_nxt[`PRM_B_FLAG_ANY]  = evt_any;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_flags_r <= `PRM_RST_ZERO;
            irq_r       <= 1'b0;
        end
        else
        begin
            irq_flags_r <= flags_nxt;
            irq_r       <= flags_nxt[`PRM_B_FLAG_ANY];
        end
    end

    assign spi_sdo_o    = sdo_r;
    assign spi_sdo_oe_o = sdo_oe_r;
    assign irq_o        = irq_r;

endmodule // prm_reg_map

// ===== tb/prm_reg_map_checker.sv
// Purpose: Port checks on the serial slave and the threshold interrupt.
// Assumes: Serial pins pass a two-stage synchroniser inside the map.
// Notes:   Bounds allow for that synchroniser delay.
`timescale 1ns/1ns
module prm_reg_map_checker (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_clk_i,
    input wire logic spi_sdo_o,
    input wire logic spi_sdo_oe_o,
    input wire logic meas_valid_i,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_idle; spi_cs_n_i[*6]; endsequence
    property p_oe_rise; $rose(spi_sdo_oe_o) |-> !spi_cs_n_i; endproperty
    property p_oe_off; $rose(spi_cs_n_i) |-> ##[1:5] !spi_sdo_oe_o; endproperty
    property p_oe_idle; s_idle |-> !spi_sdo_oe_o; endproperty
    property p_oe_cmd; $fell(spi_cs_n_i) |-> (!spi_sdo_oe_o)[*8]; endproperty
    property p_sdo_edge; $changed(spi_sdo_o) && spi_sdo_oe_o && !spi_cs_n_i |-> !spi_clk_i;
    endproperty
    property p_sdo_quiet; s_idle ##1 spi_cs_n_i |-> $stable(spi_sdo_o); endproperty
    property p_irq_rise; $rose(irq_o) |-> $past(meas_valid_i) || $past(meas_valid_i, 2);
    endproperty
    // A latched request may also drop when the flag register is read inside a frame.
    property p_irq_fall; $fell(irq_o) |-> $past(meas_valid_i) || $past(meas_valid_i, 2)
        || !$past(spi_cs_n_i, 2); endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("sdo enable outside frame");
    a_oe_off: assert property (p_oe_off) else $error("sdo enable held after frame");
    a_oe_idle: assert property (p_oe_idle) else $error("sdo enable while idle");
    a_oe_cmd: assert property (p_oe_cmd) else $error("sdo driven in command byte");
    a_sdo_edge: assert property (p_sdo_edge) else $error("sdo moved with clock high");
    a_sdo_quiet: assert property (p_sdo_quiet) else $error("sdo moved while idle");
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without sample");
    a_irq_fall: assert property (p_irq_fall) else $error("stray irq fall");
endmodule // prm_reg_map_checker
bind prm_reg_map prm_reg_map_checker u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .spi_cs_n_i(spi_cs_n_i), .spi_clk_i(spi_clk_i), .spi_sdo_o(spi_sdo_o),
    .spi_sdo_oe_o(spi_sdo_oe_o), .meas_valid_i(meas_valid_i), .irq_o(irq_o));

// ===== tb/prm_host.sv
// Purpose: Host model driving four-wire serial frames.
// Assumes: Serial clock idles high; each half bit lasts eight core clocks.
// Notes:   A released sdo line reads as a level that toggles every cycle.
`timescale 1ns/1ns
module prm_host (
    input  wire logic core_clk_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      sdi_o,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i
);
    logic last_r;
    wire  line_w = sdo_oe_i ? sdo_i : ~last_r;
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        sdi_o = 1'b0;
        last_r = 1'b0;
    end
    always @(posedge core_clk_i) last_r <= line_w;
    task half;
        repeat (8) @(negedge core_clk_i);
    endtask
    // The bench passes mapped addresses and one unmapped address, 7'h2d.
    task xfer(input logic rw, input logic [6:0] a, input int n, input logic [23:0] wd,
              output logic [23:0] rd);
        int i;
        rd = 24'h000000;
        cs_n_o = 1'b0;
        half();
        for (i = 0; i < 8 + 8 * n; i++)
        begin
            sclk_o = 1'b0;
            sdi_o = (i == 0) ? rw : (i < 8) ? a[7 - i] : wd[8 * n - 1 - (i - 8)];
            half();
            sclk_o = 1'b1;
            if (i >= 8) rd = {rd[22:0], line_w};
            half();
        end
        cs_n_o = 1'b1;
        half();
    endtask
endmodule // prm_host

// ===== tb/test_pressure_reg_map_threshold_irq.sv
// Purpose: Register and threshold interrupt tests through serial frames.
// Assumes: Conversions are single-cycle pulses on the core clock.
// Notes:   Host reads reserved address 7'h2d once; it never touches calibration space.
`timescale 1ns/1ns
module test_pressure_reg_map_threshold_irq;
    // Arbitrary identity value.
    localparam logic [7:0] ID = 8'h5a;
    logic        clk, rst, cs_n, sclk, sdi, sdo, oe, mv, irq;
    logic [23:0] mp, junk, v;
    logic [15:0] mt;
    int          n_mismatch, n_checks;
    prm_reg_map #(.ID_VALUE(ID)) dut (.core_clk_i(clk), .rst_i(rst), .spi_cs_n_i(cs_n),
        .spi_clk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(oe),
        .meas_valid_i(mv), .meas_press_i(mp), .meas_temp_i(mt), .irq_o(irq));
    prm_host host (.core_clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
        .sdo_i(sdo), .sdo_oe_i(oe));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [6:0] a, input int n, input logic [23:0] d);
        host.xfer(1'b0, a, n, d, junk);
    endtask
    task rc(input logic [6:0] a, input int n, input logic [23:0] e);
        host.xfer(1'b1, a, n, 24'h000000, v);
        chk(v, e);
    endtask
    // The irq check waits one extra edge so the registered answer has landed.
    task ms(input logic [23:0] p, input logic e);
        @(negedge clk);
        mv = 1'b1;
        mp = p;
        mt = p[15:0];
        @(negedge clk);
        mv = 1'b0;
        @(negedge clk);
        chk({23'h0, irq}, {23'h0, e});
    endtask
    initial
    begin
        {rst, mv, mp, mt, n_mismatch, n_checks} = {1'b1, 41'h0, 64'h0};
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        rc(7'h11, 1, 24'h000010);
        rc(7'h0b, 1, 24'h000000);
        rc(7'h0f, 1, {16'h0, ID});
        rc(7'h2d, 1, 24'h000000);
        wr(7'h0c, 2, 24'h000201);
        rc(7'h0c, 2, 24'h000201);
        wr(7'h0b, 1, 24'h00000d);
        ms(24'h010200, 1'b0);
        ms(24'h010201, 1'b1);
        ms(24'h000000, 1'b1);
        rc(7'h25, 1, 24'h000005);
        chk({23'h0, irq}, 24'h000000);
        wr(7'h0b, 1, 24'h00002a);
        ms(24'h300000, 1'b0);
        rc(7'h15, 3, 24'h000030);
        rc(7'h0b, 1, 24'h00000a);
        ms(24'h2efdff, 1'b1);
        rc(7'h28, 3, 24'hfffdfe);
        rc(7'h27, 1, 24'h000002);
        rc(7'h2b, 2, 24'h00fffd);
        rc(7'h27, 1, 24'h000000);
        ms(24'h300000, 1'b0);
        wr(7'h0b, 1, 24'h00001a);
        rc(7'h15, 3, 24'h000000);
        rc(7'h0b, 1, 24'h00000a);
        wr(7'h18, 2, 24'h001000);
        wr(7'h0b, 1, 24'h000080);
        ms(24'h100000, 1'b0);
        rc(7'h28, 3, 24'hf0ff0f);
        rc(7'h15, 3, 24'h000010);
        rc(7'h0b, 1, 24'h000000);
        wr(7'h0b, 1, 24'h000040);
        ms(24'h100000, 1'b0);
        rc(7'h28, 3, 24'h000010);
        wr(7'h11, 1, 24'h000000);
        wr(7'h0c, 2, 24'h003344);
        rc(7'h0c, 1, 24'h000044);
        rc(7'h0d, 1, 24'h000001);
        close_out();
    end
endmodule // test_pressure_reg_map_threshold_irq
